// ### src/serdes_pll_pkg.sv
/*
 * constants shared by the serdes pll control block: register indices,
 * field positions, reset values, interrupt layout and timing.
 * assumes a 32-bit axi4-lite register bus with 8-bit registers in the low lane.
 */
package serdes_pll_pkg;

    localparam int unsigned ADDR_W = 12;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_EQ_BIAS   = 10'h268;
    localparam logic [9:0] IDX_SYNTH_EN  = 10'h280;
    localparam logic [9:0] IDX_PLL_FLAGS = 10'h281;
    localparam logic [9:0] IDX_PREDIV    = 10'h289;
    localparam logic [9:0] IDX_IRQ_STAT  = 10'h290;
    localparam logic [9:0] IDX_IRQ_MASK  = 10'h291;

    localparam logic [7:0] RST_EQ_BIAS  = 8'h44;
    localparam logic [7:0] RST_SYNTH_EN = 8'h00;
    localparam logic [1:0] RST_PREDIV   = 2'h0;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;

    localparam int unsigned EQ_PWR_LSB      = 6;
    localparam int unsigned BIT_ENABLE      = 0;
    localparam int unsigned BIT_RESV1       = 1;
    localparam int unsigned BIT_RECAL       = 2;
    localparam int unsigned FLG_LOCK        = 0;
    localparam int unsigned FLG_CAL_VALID   = 3;
    localparam int unsigned FLG_BELOW       = 4;
    localparam int unsigned FLG_ABOVE       = 5;

    // interrupt status and mask layout
    localparam int unsigned IRQ_N           = 4;
    localparam int unsigned IRQ_LOCK_GAINED = 0;
    localparam int unsigned IRQ_LOCK_LOST   = 1;
    localparam int unsigned IRQ_CAL_DONE    = 2;
    localparam int unsigned IRQ_RANGE_FAULT = 3;

    // predivider codes and ratios
    localparam logic [1:0] PREDIV_BY4  = 2'h0;
    localparam logic [1:0] PREDIV_BY2  = 2'h1;
    localparam logic [1:0] PREDIV_LOW  = 2'h2;
    localparam int unsigned RATIO_BY4  = 4;
    localparam int unsigned RATIO_BY2  = 2;
    localparam int unsigned RATIO_LOW  = 1;

    // power-up settling of the pll currents before calibration starts
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned PWRUP_TIME_NS  = 1000;
    localparam int unsigned PWRUP_CYCLES   = (PWRUP_TIME_NS * CLK_MHZ + 999) / 1000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_POWERUP,
        ST_CALIBRATE,
        ST_RUN
    } pll_state_t;

endpackage

// ### src/sticky_flag.sv
/*
 * row of sticky event bits, cleared by a clear mask that may hold any number of ones.
 * assumes set and clear are single-cycle qualified pulses in the clk_sys domain.
 */
module sticky_flag #(
    parameter int unsigned W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic [W-1:0] setPulse,
    input  wire logic [W-1:0] clrMask,
    output logic      [W-1:0] flags_ff
);

    // a set in the clearing cycle survives
    wire logic [W-1:0] nxt_flags = (flags_ff & ~clrMask) | setPulse;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            flags_ff <= '0;
        else
            flags_ff <= nxt_flags;
    end

endmodule

// ### src/ref_predivider.sv
/*
 * reference predivider: passes one of every n reference ticks on to the
 * phase frequency detector tick.
 * assumes refTick is a one-cycle pulse synchronous to clk_sys.
 */
module ref_predivider
    import serdes_pll_pkg::*;
#(
    parameter int unsigned RATIO_A = RATIO_BY4,
    parameter int unsigned RATIO_B = RATIO_BY2,
    parameter int unsigned RATIO_C = RATIO_LOW
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       refTick,
    input  wire logic [1:0] divSelect,
    output logic            pfdTick_ff
);

    logic [2:0] count_ff;
    logic [1:0] selSeen_ff;
    logic [2:0] ratioM1;

    // reserved code 11 falls back to the widest ratio
    always_comb
    begin
        unique case (divSelect)
            PREDIV_BY2: ratioM1 = 3'(RATIO_B - 1);
            PREDIV_LOW: ratioM1 = 3'(RATIO_C - 1);
            default:    ratioM1 = 3'(RATIO_A - 1);
        endcase
    end

    wire logic selChanged = (selSeen_ff != divSelect);
    wire logic wrap       = refTick && (count_ff >= ratioM1);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            count_ff   <= '0;
            selSeen_ff <= RST_PREDIV;
            pfdTick_ff <= 1'b0;
        end
        else
        begin
            selSeen_ff <= divSelect;
            pfdTick_ff <= wrap && !selChanged;
            if (selChanged || wrap)
                count_ff <= '0;
            else if (refTick)
                count_ff <= count_ff + 3'h1;
        end
    end

endmodule

// ### src/serdes_pll_control_status.sv
/*
 * register-side control and status of the receive serdes pll: enable and
 * calibration sequencing, recalibration on request, reference predivider,
 * live status flags, equalizer power setting, event interrupt.
 * assumes the analog pll reports calibration done, validity, lock and
 * charge pump range as levels synchronous to clk_sys.
 */
// Design decision made here: the AXI4-Lite slave port.
// How it works
// (RQ1) recalibrate request rising edge reruns calibration
// (RQ2) software drops request before raising it again
// (RQ3) enable powers up currents, then calibrates
// (RQ4) software checks reference and dividers before enabling
// (RQ5) flag shows charge pump above range
// (RQ6) flag shows charge pump below range
// (RQ7) calibration valid bit reads finished valid result
// (RQ8) lock bit follows synthesizer lock
// (RQ9) predivider divides reference before phase detector
// (RQ10) software keeps divided reference within limits
// (RQ11) code 00 divides reference by four
// (RQ12) code 01 divides reference by two
// (RQ13) code 10 selects lowest lane rate ratio
// (RQ14) equalizer power setting field, resets to one
// (RQ15) lock and valid read zero while disabled
module serdes_pll_control_status
    import serdes_pll_pkg::*;
#(
    parameter int unsigned LOW_RATE_RATIO = RATIO_LOW
) (
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    // axi4-lite slave
    input  wire logic [serdes_pll_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [serdes_pll_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // analog pll side
    input  wire logic                      refTick,
    input  wire logic                      pllCalDone,
    input  wire logic                      pumpCalValidIn,
    input  wire logic                      synthLockedIn,
    input  wire logic                      pumpAboveIn,
    input  wire logic                      pumpBelowIn,
    output logic                           pllPowerEnable,
    output logic                           pllCalStart,
    output logic                           pfdTick,
    output logic [1:0]                     referencePredivideSelect,
    output logic [1:0]                     equalizerPowerSetting,
    output logic                           irq
);

    localparam logic [7:0] PWRUP_LAST = 8'(PWRUP_CYCLES - 1);

    // ---------------- bus write path ----------------
    logic                awHeld_ff;
    logic                wHeld_ff;
    logic [ADDR_W-1:0]   awAddr_ff;
    logic [7:0]          wData_ff;
    logic                wLane_ff;
    logic                bvalid_ff;
    logic [1:0]          bresp_ff;

    assign s_axi_awready = !awHeld_ff && !bvalid_ff;
    assign s_axi_wready  = !wHeld_ff && !bvalid_ff;

    wire logic awTake   = s_axi_awvalid && s_axi_awready;
    wire logic wTake    = s_axi_wvalid && s_axi_wready;
    wire logic wrFire   = awHeld_ff && wHeld_ff && !bvalid_ff;
    wire logic [9:0] wrIdx = awAddr_ff[ADDR_W-1:2];

    wire logic hitEqW    = (wrIdx == IDX_EQ_BIAS);
    wire logic hitSynW   = (wrIdx == IDX_SYNTH_EN);
    wire logic hitFlagW  = (wrIdx == IDX_PLL_FLAGS);
    wire logic hitDivW   = (wrIdx == IDX_PREDIV);
    wire logic hitStatW  = (wrIdx == IDX_IRQ_STAT);
    wire logic hitMaskW  = (wrIdx == IDX_IRQ_MASK);
    wire logic wrMapped  = hitEqW || hitSynW || hitFlagW || hitDivW || hitStatW || hitMaskW;
    // writes to the read-only flag register are accepted and dropped
    wire logic wrStore   = wrFire && wLane_ff;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= '0;
        end
        else if (awTake)
        begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
        end
        else if (wrFire)
            awHeld_ff <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wHeld_ff <= 1'b0;
            wData_ff <= '0;
            wLane_ff <= 1'b0;
        end
        else if (wTake)
        begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata[7:0];
            wLane_ff <= s_axi_wstrb[0];
        end
        else if (wrFire)
            wHeld_ff <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end
        else if (wrFire)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // ---------------- control registers ----------------
    logic [7:0]       eqBias_ff;
    logic [2:0]       synthCtl_ff;
    logic [1:0]       prediv_ff;
    logic [IRQ_N-1:0] irqMask_ff;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            eqBias_ff   <= RST_EQ_BIAS;    // [RQ14]
            synthCtl_ff <= RST_SYNTH_EN[2:0];
            prediv_ff   <= RST_PREDIV;
            irqMask_ff  <= RST_IRQ_MASK;
        end
        else if (wrStore)
        begin
            if (hitEqW)
                eqBias_ff <= wData_ff;     // [RQ14]
            if (hitSynW)
                synthCtl_ff <= wData_ff[2:0];
            if (hitDivW)
                prediv_ff <= wData_ff[1:0];
            if (hitMaskW)
                irqMask_ff <= wData_ff[IRQ_N-1:0];
        end
    end

    wire logic enableBit = synthCtl_ff[BIT_ENABLE];
    wire logic recalBit  = synthCtl_ff[BIT_RECAL];

    // ---------------- calibration sequencer ----------------
    pll_state_t state_ff;
    pll_state_t nxt_state;
    logic [7:0] settle_ff;
    logic       recalSeen_ff;
    logic       calStart_ff;

    // only a 0 to 1 change of the stored bit asks again; holding it high does nothing
    wire logic recalRise = recalBit && !recalSeen_ff;   // [RQ1] [RQ2]
    wire logic settled   = (settle_ff == PWRUP_LAST);
    wire logic calFinish = (state_ff == ST_CALIBRATE) && pllCalDone && !calStart_ff;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_OFF:
                if (enableBit)
                    nxt_state = ST_POWERUP;                 // [RQ3]
            ST_POWERUP:
                if (settled)
                    nxt_state = ST_CALIBRATE;               // [RQ3]
            ST_CALIBRATE:
                if (calFinish)
                    nxt_state = ST_RUN;
            ST_RUN:
                if (recalRise)
                    nxt_state = ST_CALIBRATE;               // [RQ1]
        endcase
        if (!enableBit)
            nxt_state = ST_OFF;
    end

    // a recalibration request during calibration restarts it
    wire logic startCal = enableBit &&
                          ((state_ff == ST_POWERUP && settled) ||
                           (state_ff != ST_OFF && state_ff != ST_POWERUP && recalRise));

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff     <= ST_OFF;
            settle_ff    <= '0;
            recalSeen_ff <= 1'b0;
            calStart_ff  <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            recalSeen_ff <= recalBit;
            calStart_ff  <= startCal;                        // [RQ1] [RQ3]
            if (state_ff == ST_POWERUP && !settled)
                settle_ff <= settle_ff + 8'h1;
            else if (state_ff != ST_POWERUP)
                settle_ff <= '0;
        end
    end

    assign pllPowerEnable = (state_ff != ST_OFF);            // [RQ3]
    assign pllCalStart    = calStart_ff;

    // ---------------- live status flags ----------------
    wire logic running     = (state_ff == ST_RUN);
    wire logic lockFlag    = enableBit && synthLockedIn;                 // [RQ8] [RQ15]
    wire logic validFlag   = enableBit && running && pumpCalValidIn;     // [RQ7] [RQ15]
    wire logic aboveFlag   = pumpAboveIn;                                // [RQ5]
    wire logic belowFlag   = pumpBelowIn;                                // [RQ6]

    logic [7:0] flags_ff;
    wire logic [7:0] nxt_flags = (8'(aboveFlag) << FLG_ABOVE) | (8'(belowFlag) << FLG_BELOW) |
                                 (8'(validFlag) << FLG_CAL_VALID) | (8'(lockFlag) << FLG_LOCK);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            flags_ff <= '0;
        else
            flags_ff <= nxt_flags;
    end

    // ---------------- events and interrupt ----------------
    logic [IRQ_N-1:0] irqStat_ff;
    wire logic [IRQ_N-1:0] flagPrev = {flags_ff[FLG_ABOVE] | flags_ff[FLG_BELOW], 1'b0,
                                       flags_ff[FLG_LOCK], flags_ff[FLG_LOCK]};
    wire logic lockNow  = nxt_flags[FLG_LOCK];
    wire logic faultNow = nxt_flags[FLG_ABOVE] | nxt_flags[FLG_BELOW];

    logic [IRQ_N-1:0] evSet;
    always_comb
    begin
        evSet = '0;
        evSet[IRQ_LOCK_GAINED] = lockNow && !flagPrev[IRQ_LOCK_GAINED];
        evSet[IRQ_LOCK_LOST]   = !lockNow && flagPrev[IRQ_LOCK_LOST];
        evSet[IRQ_CAL_DONE]    = calFinish;
        evSet[IRQ_RANGE_FAULT] = faultNow && !flagPrev[IRQ_RANGE_FAULT];
    end

    wire logic [IRQ_N-1:0] evClr = (wrStore && hitStatW) ? wData_ff[IRQ_N-1:0] : '0;

    sticky_flag #(
        .W        (IRQ_N)
    ) u_events (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .setPulse (evSet),
        .clrMask  (evClr),
        .flags_ff (irqStat_ff)
    );

    assign irq = |(irqStat_ff & irqMask_ff);

    // ---------------- reference predivider ----------------
    ref_predivider #(
        .RATIO_A    (RATIO_BY4),       // [RQ11]
        .RATIO_B    (RATIO_BY2),       // [RQ12]
        .RATIO_C    (LOW_RATE_RATIO)   // [RQ13]
    ) u_prediv (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .refTick    (refTick),
        .divSelect  (prediv_ff),       // [RQ9]
        .pfdTick_ff (pfdTick)
    );

    assign referencePredivideSelect = prediv_ff;                     // [RQ9]
    assign equalizerPowerSetting    = eqBias_ff[EQ_PWR_LSB +: 2];    // [RQ14]

    // ---------------- bus read path ----------------
    logic        rvalid_ff;
    logic [7:0]  rdata_ff;
    logic [1:0]  rresp_ff;

    assign s_axi_arready = !rvalid_ff;
    wire logic arTake = s_axi_arvalid && s_axi_arready;
    wire logic [9:0] rdIdx = s_axi_araddr[ADDR_W-1:2];

    wire logic hitEqR   = (rdIdx == IDX_EQ_BIAS);
    wire logic hitSynR  = (rdIdx == IDX_SYNTH_EN);
    wire logic hitFlagR = (rdIdx == IDX_PLL_FLAGS);
    wire logic hitDivR  = (rdIdx == IDX_PREDIV);
    wire logic hitStatR = (rdIdx == IDX_IRQ_STAT);
    wire logic hitMaskR = (rdIdx == IDX_IRQ_MASK);
    wire logic rdMapped = hitEqR || hitSynR || hitFlagR || hitDivR || hitStatR || hitMaskR;

    wire logic [7:0] rdMux = ({8{hitEqR}}   & eqBias_ff) |
                             ({8{hitSynR}}  & {5'h00, synthCtl_ff}) |
                             ({8{hitFlagR}} & flags_ff) |
                             ({8{hitDivR}}  & {6'h00, prediv_ff}) |
                             ({8{hitStatR}} & {4'h0, irqStat_ff}) |
                             ({8{hitMaskR}} & {4'h0, irqMask_ff});

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end
        else if (arTake)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rdMux;
            rresp_ff  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp  = rresp_ff;
    assign s_axi_rdata  = {24'h000000, rdata_ff};

endmodule

// ### verification/serdes_pll_control_status_asserts.sv
/*
 * concurrent checks on the serdes pll control block ports.
 * assumes it is bound to serdes_pll_control_status, one clock domain.
 */
module serdes_pll_control_status_asserts
    import serdes_pll_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       refTick,
    input wire logic       pllPowerEnable,
    input wire logic       pllCalStart,
    input wire logic       pfdTick,
    input wire logic [1:0] equalizerPowerSetting
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_start_powered: assert property (pllCalStart |-> pllPowerEnable)
        else $error("cal start while pll unpowered");
    // at least eight cycles must pass after power up before the first calibration pulse
    a_powerup_then_cal: assert property ($rose(pllPowerEnable) |->
        (!pllCalStart)[*8] ##[1:300] pllCalStart)
        else $error("calibration not started after power up");
    a_cal_single_pulse: assert property (pllCalStart |=> !pllCalStart)
        else $error("cal start longer than one cycle");
    a_pfd_from_ref: assert property (pfdTick |-> $past(refTick))
        else $error("pfd tick without reference tick");
    a_eq_reset_one: assert property ($rose(resetn) |-> equalizerPowerSetting == 2'h1)
        else $error("equalizer power setting reset value");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while answer pending");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
endmodule

bind serdes_pll_control_status serdes_pll_control_status_asserts asserts_u (
    .clk_sys, .resetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_bvalid, .s_axi_bready, .refTick, .pllPowerEnable, .pllCalStart, .pfdTick,
    .equalizerPowerSetting);

// ### verification/serdes_pll_control_status_tb_top.sv
/*
 * self-checking bench for the serdes pll control block over axi4-lite.
 * assumes the bench plays both the register master and the analog pll.
 */
module serdes_pll_control_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import serdes_pll_pkg::*;

    logic clk_sys = 1'b0, resetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, referencePredivideSelect, equalizerPowerSetting;
    logic refTick = 1'b0, refOn = 1'b0, pllCalDone = 1'b0, pumpCalValidIn = 1'b0;
    logic synthLockedIn = 1'b0, pumpAboveIn = 1'b0, pumpBelowIn = 1'b0;
    logic pllPowerEnable, pllCalStart, pfdTick, irq;
    int   mismatches = 0, n_tests = 0, cyc = 0, calStarts = 0, pfdCount = 0;

    serdes_pll_control_status dut_u (.*);

    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        refTick <= refOn & ~refTick;
        if (pllCalStart) calStarts <= calStarts + 1;
        if (pfdTick) pfdCount <= pfdCount + 1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // entered right after a rising edge; handshakes are sampled at the
    // falling edge so the decision never races the design's own updates
    task automatic axiWrite(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] resp);
        logic aw, w, b;
        int   n;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b = 1'b0;
        for (n = 0; n < 50 && !b; n++)
        begin
            @(negedge clk_sys);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk_sys);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        if (!b) check("write timeout", 32'h1, 32'h0);
    endtask

    task automatic axiRead(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] resp);
        logic ar, r;
        int   n;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        r = 1'b0;
        for (n = 0; n < 50 && !r; n++)
        begin
            @(negedge clk_sys);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_sys);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        if (!r) check("read timeout", 32'h1, 32'h0);
    endtask

    task automatic expectReg(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  rs;
        axiRead(idx, d, rs);
        check("read data", d, exp);
        check("read resp", 32'(rs), 32'(er));
    endtask

    task automatic waitCal(input int target);
        int n;
        for (n = 0; n < 400 && calStarts < target; n++) @(negedge clk_sys);
        check("cal start count", 32'(calStarts), 32'(target));
        @(posedge clk_sys);
    endtask

    task automatic resetScen();
        expectReg(IDX_EQ_BIAS, 32'h44, RESP_OKAY);
        expectReg(IDX_SYNTH_EN, 32'h0, RESP_OKAY);
        expectReg(IDX_PLL_FLAGS, 32'h0, RESP_OKAY);
        expectReg(IDX_PREDIV, 32'h0, RESP_OKAY);
        expectReg(IDX_IRQ_MASK, 32'h0, RESP_OKAY);
        expectReg(IDX_IRQ_STAT, 32'h0, RESP_OKAY);
        expectReg(10'h3ff, 32'h0, RESP_SLVERR);
    endtask

    task automatic eqScen();
        logic [1:0] rs;
        axiWrite(IDX_EQ_BIAS, 8'h84, rs);
        check("eq write resp", 32'(rs), 32'(RESP_OKAY));
        check("eq power pin", 32'(equalizerPowerSetting), 32'h2);
        expectReg(IDX_EQ_BIAS, 32'h84, RESP_OKAY);
        axiWrite(10'h3ff, 8'h11, rs);
        check("unmapped write resp", 32'(rs), 32'(RESP_SLVERR));
    endtask

    task automatic predivScen(input logic [1:0] code, input int ratio);
        logic [1:0] rs;
        int         n;
        axiWrite(IDX_PREDIV, {6'h0, code}, rs);
        check("predivide pin", 32'(referencePredivideSelect), 32'(code));
        expectReg(IDX_PREDIV, 32'(code), RESP_OKAY);
        refOn <= 1'b1;
        repeat (16) @(negedge clk_sys);
        n = pfdCount;
        // 48 cycles hold 24 reference ticks at one tick every other cycle
        repeat (48) @(negedge clk_sys);
        check("pfd ticks", 32'(pfdCount - n), 32'(24 / ratio));
        @(posedge clk_sys);
    endtask

    task automatic pllScen();
        logic [1:0] rs;
        int         t0;
        axiWrite(IDX_IRQ_MASK, 8'(1 << IRQ_CAL_DONE), rs);
        t0 = cyc;
        axiWrite(IDX_SYNTH_EN, 8'(1 << BIT_ENABLE), rs);
        // the state register moves on the edge the task returns at; look once it has settled
        @(negedge clk_sys);
        check("power enable", 32'(pllPowerEnable), 32'h1);
        waitCal(1);
        check("powerup wait", 32'(cyc - t0 >= PWRUP_CYCLES), 32'h1);
        pllCalDone <= 1'b1;
        pumpCalValidIn <= 1'b1;
        synthLockedIn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        expectReg(IDX_PLL_FLAGS, (32'h1 << FLG_LOCK) | (32'h1 << FLG_CAL_VALID),
                  RESP_OKAY);
        check("irq cal done", 32'(irq), 32'h1);
        axiWrite(IDX_IRQ_STAT, 8'(1 << IRQ_CAL_DONE), rs);
        check("irq cleared", 32'(irq), 32'h0);
        axiWrite(IDX_SYNTH_EN, 8'h05, rs);
        waitCal(2);
        axiWrite(IDX_SYNTH_EN, 8'h05, rs);
        repeat (4) @(posedge clk_sys);
        check("no recal on held bit", 32'(calStarts), 32'h2);
        axiWrite(IDX_SYNTH_EN, 8'h01, rs);
        axiWrite(IDX_SYNTH_EN, 8'h05, rs);
        waitCal(3);
        pumpCalValidIn <= 1'b0;
        pumpAboveIn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        expectReg(IDX_PLL_FLAGS, (32'h1 << FLG_LOCK) | (32'h1 << FLG_ABOVE),
                  RESP_OKAY);
        // each finished recalibration sets the calibration event again
        check("irq recal done", 32'(irq), 32'h1);
        axiWrite(IDX_IRQ_STAT, 8'(1 << IRQ_CAL_DONE), rs);
        check("range fault masked", 32'(irq), 32'h0);
        axiWrite(IDX_IRQ_MASK, 8'(1 << IRQ_RANGE_FAULT), rs);
        check("range fault irq", 32'(irq), 32'h1);
        pumpCalValidIn <= 1'b1;
        pumpAboveIn <= 1'b0;
        pumpBelowIn <= 1'b1;
        axiWrite(IDX_SYNTH_EN, 8'h00, rs);
        repeat (3) @(posedge clk_sys);
        check("power disabled", 32'(pllPowerEnable), 32'h0);
        // lock and valid inputs stay high, yet a disabled pll reports neither
        expectReg(IDX_PLL_FLAGS, 32'h1 << FLG_BELOW, RESP_OKAY);
        axiWrite(IDX_PLL_FLAGS, 8'hff, rs);
        check("ro write resp", 32'(rs), 32'(RESP_OKAY));
        expectReg(IDX_PLL_FLAGS, 32'h1 << FLG_BELOW, RESP_OKAY);
    endtask

    initial
    begin
        #200000;
        mismatches++;
        complete_run();
    end

    initial
    begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        resetScen();
        eqScen();
        predivScen(PREDIV_BY4, RATIO_BY4);
        predivScen(PREDIV_BY2, RATIO_BY2);
        predivScen(PREDIV_LOW, RATIO_LOW);
        pllScen();
        complete_run();
    end
endmodule
